/* File: shared/arct_pkg.sv */
// Purpose: constants for the auto-reload capture timer
// Assumes: apb slave, 32-bit data, one word per register
// Notes: offsets are byte addresses
package arct_pkg;
  localparam logic [7:0] ARCT_OFS_CTRL = 8'h00;
  localparam logic [7:0] ARCT_OFS_CNTL = 8'h04;
  localparam logic [7:0] ARCT_OFS_CNTH = 8'h08;
  localparam logic [7:0] ARCT_OFS_RLDL = 8'h0C;
  localparam logic [7:0] ARCT_OFS_RLDH = 8'h10;
  localparam logic [7:0] ARCT_OFS_CLOCK_CONTROL_REG = 8'h14;
  localparam logic [7:0] ARCT_OFS_IEN = 8'h18;
  // control register fields
  localparam int ARCT_B_HOVF = 7;
  localparam int ARCT_B_LOVF = 6;
  localparam int ARCT_B_LIEN = 5;
  localparam int ARCT_B_CAPEN = 4;
  localparam int ARCT_B_SPLIT = 3;
  localparam int ARCT_B_RUN = 2;
  localparam int ARCT_B_XSEL = 0;
  // clock control fields
  localparam int ARCT_B_LSYS = 0;
  localparam int ARCT_B_HSYS = 1;
  // interrupt enable field
  localparam int ARCT_B_TIEN = 0;
  localparam logic [7:0] ARCT_RST_BYTE = 8'h00;
  localparam logic [3:0] ARCT_DIV_SYS = 4'hB;
  localparam logic [2:0] ARCT_DIV_EXT = 3'h7;
  typedef enum logic [1:0] {
    ARCT_SRC_SYS12 = 2'b00,
    ARCT_SRC_EXT8 = 2'b01,
    ARCT_SRC_SYS12B = 2'b10,
    ARCT_SRC_CMP = 2'b11
  } arct_src_t;
endpackage

/* File: design/arct_sync.sv */
// Purpose: two-stage synchroniser with rising-edge pulse
// Assumes: d is asynchronous to clk
// Notes: edge detect compares the second stage with registered q
`timescale 1ns/1ps
module arct_sync (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic d, // async level
  output logic q, // synchronised level
  output logic rise // one-cycle pulse on rise
);
  logic s1_r;
  logic s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      q <= s2_r;
    end
  end
  assign rise = s2_r & ~q;
endmodule

/* File: design/arct_timer.sv */
// Purpose: 16-bit / dual 8-bit auto-reload timer with capture mode
// Assumes: apb slave on pclk; ext_osc and cmp_out asynchronous
// Notes: flags cleared only by software writes; set wins
// Contract
// - count held as low and high bytes
// - split clear gives one 16-bit auto-reload counter
// - 16-bit wrap reloads and sets high flag; with capture enable set the count wraps to zero, no reload
// - 16-bit overflow interrupts when timer enabled
// - low-byte wrap interrupts when low enable too
// - four count clock sources
// - external sources synchronised before use
// - split set gives two 8-bit reload timers
// - split run bit gates only high half
// - per-half system_clock select, else external select
// - split mode sets each half's flag
// - split interrupts on high, either with enable
// - hardware never clears flags; software does
// - capture enable selects capture mode
// - capture on comparator rise or ext/8
// - capture copies count to reload, sets flag
// - low flag set on every low wrap
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module arct_timer (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic ext_osc, // external oscillator, async
  input wire logic cmp_out, // comparator output, async
  output logic irq // timer interrupt request, level
);
  import arct_pkg::*;

  logic [7:0] cnt_lo_r, cnt_hi_r, rld_lo_r, rld_hi_r;
  logic hovf_r, lovf_r, lien_r, capen_r, split_r, run_r;
  logic [1:0] xsel_r;
  logic lsys_r, hsys_r, tien_r;
  logic [3:0] div12_r;
  logic [2:0] div8_r;
  logic sys12_tick, ext8_tick, ext_rise, cmp_rise;
  logic lo_tick, hi_tick, lo_wrap, hi_wrap, cap_ev, wide_wrap;
  logic acc, wr, mapped;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign mapped = (paddr <= ARCT_OFS_IEN) && (paddr[1:0] == 2'b00);

  // level outputs unused: only rising edges advance or capture
  arct_sync u_ext (
    .pclk(pclk), .presetn(presetn), .d(ext_osc), .q(), .rise(ext_rise)
  );
  arct_sync u_cmp (
    .pclk(pclk), .presetn(presetn), .d(cmp_out), .q(), .rise(cmp_rise)
  );

  // prescalers: system_clock/12 and synchronised ext/8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_r <= 4'h0;
    end else if (div12_r == ARCT_DIV_SYS) begin
      div12_r <= 4'h0;
    end else begin
      div12_r <= div12_r + 4'h1;
    end
  end
  assign sys12_tick = (div12_r == ARCT_DIV_SYS);

  // ext/8 counts synchronised rises only, never raw edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div8_r <= 3'h0;
    end else if (ext_rise) begin
      div8_r <= div8_r + 3'h1;
    end
  end
  assign ext8_tick = ext_rise && (div8_r == ARCT_DIV_EXT);

  function automatic logic sel_tick(input logic sys_sel, input logic [1:0] xs,
                                    input logic t12, input logic t8, input logic tc);
    logic r;
    r = 1'b0;
    if (sys_sel) begin
      r = 1'b1;
    end else begin
      case (arct_src_t'(xs))
        ARCT_SRC_SYS12: r = t12;
        ARCT_SRC_EXT8: r = t8;
        ARCT_SRC_SYS12B: r = t12;
        ARCT_SRC_CMP: r = tc;
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  logic lsrc, hsrc;
  assign lsrc = sel_tick(lsys_r, xsel_r, sys12_tick, ext8_tick, cmp_rise);
  assign hsrc = sel_tick(hsys_r, xsel_r, sys12_tick, ext8_tick, cmp_rise);
  // in 16-bit mode low half clock drives both bytes
  assign lo_tick = split_r ? lsrc : (lsrc & run_r);
  assign hi_tick = split_r ? (hsrc & run_r) : 1'b0;
  assign lo_wrap = lo_tick && (cnt_lo_r == 8'hFF);
  assign wide_wrap = !split_r && lo_wrap && (cnt_hi_r == 8'hFF);
  assign hi_wrap = split_r ? (hi_tick && (cnt_hi_r == 8'hFF)) : wide_wrap;
  // capture event: xsel bit1 clear picks comparator, set picks ext/8
  assign cap_ev = capen_r && (xsel_r[1] ? ext8_tick : cmp_rise);

  logic wr_cntl, wr_cnth, wr_rldl, wr_rldh, wr_ctrl;
  assign wr_cntl = wr && paddr == ARCT_OFS_CNTL;
  assign wr_cnth = wr && paddr == ARCT_OFS_CNTH;
  assign wr_rldl = wr && paddr == ARCT_OFS_RLDL;
  assign wr_rldh = wr && paddr == ARCT_OFS_RLDH;
  assign wr_ctrl = wr && paddr == ARCT_OFS_CTRL;

  // low count byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_r <= ARCT_RST_BYTE;
    end else if (wr_cntl) begin
      cnt_lo_r <= pwdata[7:0];
    end else if (lo_tick) begin
      if (wide_wrap && !capen_r) begin
        cnt_lo_r <= rld_lo_r;
      end else if (split_r && lo_wrap) begin
        cnt_lo_r <= rld_lo_r;
      end else begin
        cnt_lo_r <= cnt_lo_r + 8'h01;
      end
    end
  end

  // high count byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_hi_r <= ARCT_RST_BYTE;
    end else if (wr_cnth) begin
      cnt_hi_r <= pwdata[7:0];
    end else if (split_r) begin
      if (hi_tick) begin
        cnt_hi_r <= (cnt_hi_r == 8'hFF) ? rld_hi_r : cnt_hi_r + 8'h01;
      end
    end else if (lo_wrap) begin
      cnt_hi_r <= (wide_wrap && !capen_r) ? rld_hi_r : cnt_hi_r + 8'h01;
    end
  end

  // reload pair: software or capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rld_lo_r <= ARCT_RST_BYTE;
      rld_hi_r <= ARCT_RST_BYTE;
    end else if (cap_ev) begin
      rld_lo_r <= cnt_lo_r;
      rld_hi_r <= cnt_hi_r;
    end else begin
      if (wr_rldl) begin
        rld_lo_r <= pwdata[7:0];
      end
      if (wr_rldh) begin
        rld_hi_r <= pwdata[7:0];
      end
    end
  end

  // flags: set by hardware, cleared only by software write, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hovf_r <= 1'b0;
      lovf_r <= 1'b0;
    end else begin
      if (hi_wrap || cap_ev) begin
        hovf_r <= 1'b1;
      end else if (wr_ctrl) begin
        hovf_r <= pwdata[ARCT_B_HOVF];
      end
      if (lo_wrap) begin
        lovf_r <= 1'b1;
      end else if (wr_ctrl) begin
        lovf_r <= pwdata[ARCT_B_LOVF];
      end
    end
  end

  // control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lien_r <= 1'b0;
      capen_r <= 1'b0;
      split_r <= 1'b0;
      run_r <= 1'b0;
      xsel_r <= 2'b00;
      lsys_r <= 1'b0;
      hsys_r <= 1'b0;
      tien_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        lien_r <= pwdata[ARCT_B_LIEN];
        capen_r <= pwdata[ARCT_B_CAPEN];
        split_r <= pwdata[ARCT_B_SPLIT];
        run_r <= pwdata[ARCT_B_RUN];
        xsel_r <= pwdata[ARCT_B_XSEL+:2];
      end
      if (wr && paddr == ARCT_OFS_CLOCK_CONTROL_REG) begin
        lsys_r <= pwdata[ARCT_B_LSYS];
        hsys_r <= pwdata[ARCT_B_HSYS];
      end
      if (wr && paddr == ARCT_OFS_IEN) begin
        tien_r <= pwdata[ARCT_B_TIEN];
      end
    end
  end

  // interrupt level from flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= tien_r && (hovf_r || (lien_r && lovf_r));
    end
  end

  // apb: one wait-free access, read data registered in setup
  // unmapped offsets read zero and flag pslverr
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ARCT_OFS_CTRL: rd_mux[7:0] = {hovf_r, lovf_r, lien_r, capen_r, split_r, run_r, xsel_r};
      ARCT_OFS_CNTL: rd_mux[7:0] = cnt_lo_r;
      ARCT_OFS_CNTH: rd_mux[7:0] = cnt_hi_r;
      ARCT_OFS_RLDL: rd_mux[7:0] = rld_lo_r;
      ARCT_OFS_RLDH: rd_mux[7:0] = rld_hi_r;
      ARCT_OFS_CLOCK_CONTROL_REG: rd_mux[1:0] = {hsys_r, lsys_r};
      ARCT_OFS_IEN: rd_mux[0] = tien_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
    end
  end

  // assertions
  AST_LOW_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    lo_wrap |=> lovf_r) else $error("low wrap did not set low flag");
  AST_WIDE_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (wide_wrap && !capen_r && !wr_cntl && !wr_cnth) |=> ({cnt_hi_r, cnt_lo_r} ==
    $past({rld_hi_r, rld_lo_r})) && hovf_r) else $error("16-bit reload failed");
  AST_RUN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!split_r && !run_r && !wr_cntl && !wr_cnth) |=> $stable(cnt_lo_r))
    else $error("count moved while stopped");
  AST_SPLIT_LOW_FREE: assert property (@(posedge pclk) disable iff (!presetn)
    (split_r && lsys_r && !wr_cntl && cnt_lo_r != 8'hFF) |=>
    cnt_lo_r == $past(cnt_lo_r) + 8'h01) else $error("split low half not free running");
  AST_SPLIT_HI_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (split_r && !run_r && !wr_cnth) |=> $stable(cnt_hi_r))
    else $error("split high half ran without run bit");
  AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
    cap_ev |=> ({rld_hi_r, rld_lo_r} == $past({cnt_hi_r, cnt_lo_r})) && hovf_r)
    else $error("capture did not copy count");
  sequence s_flag_set;
    hovf_r && tien_r;
  endsequence
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    s_flag_set ##1 (hovf_r && tien_r) |-> irq) else $error("no irq on high flag");
  AST_LOW_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    $past(tien_r && lien_r && lovf_r) |-> irq) else $error("no irq on low flag");
  AST_NO_HW_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (hovf_r && !wr_ctrl) |=> hovf_r) else $error("flag cleared by hardware");
  AST_SYS12: assert property (@(posedge pclk) disable iff (!presetn)
    sys12_tick |=> !sys12_tick [*8]) else $error("system_clock/12 too fast");
  AST_WIDE_HI_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!split_r && !run_r && !wr_cnth) |=> $stable(cnt_hi_r))
    else $error("high byte moved while stopped");
  AST_SPLIT_LOW_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (split_r && lo_tick && cnt_lo_r == 8'hFF && !wr_cntl) |=>
    (cnt_lo_r == $past(rld_lo_r)) && lovf_r) else $error("split low half did not reload");
  AST_SPLIT_HI_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (split_r && hi_tick && cnt_hi_r == 8'hFF && !wr_cnth) |=>
    (cnt_hi_r == $past(rld_hi_r)) && hovf_r) else $error("split high wrap missed");
  // capture steps: source event seen, then count copied and flag set
  sequence s_cap_cmp;
    capen_r && !xsel_r[1] && cmp_rise;
  endsequence
  sequence s_cap_ext;
    capen_r && xsel_r[1] && ext8_tick;
  endsequence
  AST_CAP_CMP: assert property (@(posedge pclk) disable iff (!presetn)
    s_cap_cmp |=> hovf_r && ({rld_hi_r, rld_lo_r} == $past({cnt_hi_r, cnt_lo_r})))
    else $error("comparator capture missed");
  AST_CAP_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    s_cap_ext |=> hovf_r && ({rld_hi_r, rld_lo_r} == $past({cnt_hi_r, cnt_lo_r})))
    else $error("oscillator capture missed");
endmodule

/* File: sim/arct_src_model.sv */
// Purpose: far-side sources, external oscillator and comparator output
// Assumes: both asynchronous to pclk
// Notes: oscillator stands still while ext_run is low
`timescale 1ns/1ps
module arct_src_model (
  input wire logic ext_run, // let oscillator run
  input wire logic cmp_go, // comparator trip request
  output logic ext_osc, // external oscillator
  output logic cmp_out // comparator output
);
  initial begin
    ext_osc = 1'b0;
    cmp_out = 1'b0;
  end
  // odd half period keeps phase unrelated to pclk
  always begin
    #18.5;
    if (ext_run) begin
      ext_osc = ~ext_osc;
    end
  end
  always @(cmp_go) begin
    #7 cmp_out = cmp_go;
  end
endmodule

/* File: sim/auto_reload_capture_timer_tb_top.sv */
// Purpose: self-checking bench for the timer over apb
// Assumes: zero-wait apb slave, registered outputs
// Notes: read expectations queued, checked by monitor
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module auto_reload_capture_timer_tb_top;
  import arct_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'hF9994CCD;
  logic pready, pslverr, ext_osc, cmp_out, irq, ext_run = 0, cmp_go = 0;
  logic [32:0] q[$];
  logic [32:0] x;
  logic [7:0] r;
  int num_errors = 0, checks = 0;
  always #2.5 pclk = ~pclk;
  arct_timer arct_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_osc(ext_osc), .cmp_out(cmp_out), .irq(irq));
  arct_src_model arct_src_model_i (.ext_run(ext_run), .cmp_go(cmp_go), .ext_osc(ext_osc),
    .cmp_out(cmp_out));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [7:0] e, input logic er);
    q.push_back({er, 24'h0, e});
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic er = 1'b0);
    apb(a, 1'b0, 8'h00, e, er);
  endtask
  task automatic chk_irq(input logic e);
    @(posedge pclk);
    `CHK("irq", e, irq)
  endtask
  task automatic tend(input string n);
    repeat (4) @(posedge pclk);
    $display("test %s done", n);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // monitor: oldest expectation against each completed transfer, prdata on reads only
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      x = q.pop_front();
      if (pwrite === 1'b0) `CHK("prdata", x[31:0], prdata)
      `CHK("pslverr", x[32], pslverr)
    end
  end
  initial begin
    #60us;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rs = xs(rs);
    r = rs[7:0];
    rd(ARCT_OFS_CTRL, 8'h00);
    rd(8'h1C, 8'h00, 1'b1);
    tend("reset_map");
    wr(ARCT_OFS_CLOCK_CONTROL_REG, 8'h01);
    wr(ARCT_OFS_IEN, 8'h01);
    wr(ARCT_OFS_RLDL, r);
    wr(ARCT_OFS_RLDH, 8'hFF);
    wr(ARCT_OFS_CNTL, 8'hF0);
    wr(ARCT_OFS_CNTH, 8'hFF);
    wr(ARCT_OFS_CTRL, 8'h04);
    repeat (40) @(posedge pclk);
    rd(ARCT_OFS_CNTH, 8'hFF);
    rd(ARCT_OFS_CTRL, 8'hC4);
    chk_irq(1'b1);
    wr(ARCT_OFS_CTRL, 8'h00);
    rd(ARCT_OFS_CTRL, 8'h00);
    chk_irq(1'b0);
    tend("wrap16");
    wr(ARCT_OFS_CNTH, 8'h00);
    wr(ARCT_OFS_CNTL, 8'hF0);
    wr(ARCT_OFS_CTRL, 8'h24);
    repeat (40) @(posedge pclk);
    rd(ARCT_OFS_CTRL, 8'h64);
    chk_irq(1'b1);
    wr(ARCT_OFS_CTRL, 8'h00);
    wr(ARCT_OFS_CNTL, r);
    repeat (30) @(posedge pclk);
    rd(ARCT_OFS_CNTL, r);
    tend("low_irq_stop");
    wr(ARCT_OFS_CLOCK_CONTROL_REG, 8'h03);
    wr(ARCT_OFS_CNTH, 8'h10);
    wr(ARCT_OFS_CTRL, 8'h08);
    repeat (300) @(posedge pclk);
    rd(ARCT_OFS_CNTH, 8'h10);
    rd(ARCT_OFS_CTRL, 8'h48);
    chk_irq(1'b0);
    wr(ARCT_OFS_CTRL, 8'h0C);
    repeat (300) @(posedge pclk);
    rd(ARCT_OFS_CTRL, 8'hCC);
    chk_irq(1'b1);
    tend("split");
    for (int s = 1; s < 4; s += 2) begin
      wr(ARCT_OFS_CTRL, 8'h00);
      wr(ARCT_OFS_CLOCK_CONTROL_REG, 8'h01);
      wr(ARCT_OFS_CNTH, 8'h00);
      wr(ARCT_OFS_CNTL, 8'h00);
      wr(ARCT_OFS_CTRL, 8'h14 | 8'(s));
      if (s == 3) ext_run <= 1;
      else cmp_go <= 1;
      repeat (100) @(posedge pclk);
      ext_run <= 0;
      cmp_go <= 0;
      rd(ARCT_OFS_CTRL, 8'h94 | 8'(s));
      rd(ARCT_OFS_RLDH, 8'h00);
      wr(ARCT_OFS_RLDH, 8'hFF);
    end
    tend("capture");
    wr(ARCT_OFS_CTRL, 8'h00);
    wr(ARCT_OFS_CLOCK_CONTROL_REG, 8'h00);
    wr(ARCT_OFS_CNTH, 8'h00);
    wr(ARCT_OFS_CNTL, 8'hF0);
    wr(ARCT_OFS_CTRL, 8'h06);
    repeat (100) @(posedge pclk);
    rd(ARCT_OFS_CTRL, 8'h06);
    repeat (150) @(posedge pclk);
    rd(ARCT_OFS_CTRL, 8'h46);
    tend("div12");
    complete_run();
  end
endmodule
